// ### hw/cta_alarm_status.sv
// Purpose: Critical alarm status registers, masks and open-drain alarm pins
// Assumes: Register port comes from bus logic on sys_clk_i, so it is not synced
// Assumes: Conversion results and limits are delivered on sys_clk_i
// Notes:   Alarm pins follow the status one clock after it changes
// Notes:   A read and a write in one cycle return the value before the write
// Notes:   Level limits arrive as inputs; no limit registers live here
`timescale 1ns/10ps
module cta_alarm_status (
   // Clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               reset_n_i,
   // Conversion results and thresholds
   input  wire cta_pkg::cta_meas_t   meas_i,
   input  wire logic [2:0]           chan_en_i,
   input  wire cta_pkg::cta_limits_t lim_i,
   // Register access by command code
   input  wire logic [7:0]         reg_addr_i,
   input  wire logic               reg_rd_i,
   input  wire logic               reg_wr_i,
   input  wire logic [7:0]         reg_wdata_i,
   output logic [7:0]              reg_rdata_o,
   output logic                    reg_rvalid_o,
   // Open-drain alarm pins, active low on the wire
   output logic                    alarm_out_first_o,
   output logic                    alarm_out_first_oe_o,
   output logic                    alarm_out_second_o,
   output logic                    alarm_out_second_oe_o,
   output logic                    alarm_out_third_o,
   output logic                    alarm_out_third_oe_o
);

   localparam int NL = cta_pkg::NUM_LVL;
   localparam int NC = cta_pkg::NUM_CH;

   // Status, mask and output state
   logic [NL-1:0][NC-1:0] stat_ff;
   logic [NL-1:0][NC-1:0] nxt_stat;
   logic [NL-1:0][NC-1:0] eval;
   logic [NL-1:0][NC-1:0] mask_ff;
   logic [NL-1:0][NC-1:0] nxt_mask;
   logic [NL-1:0]         alarm_ff;
   logic [NL-1:0]         nxt_alarm;
   logic [NL-1:0]         pin_ff;
   logic [NL-1:0]         nxt_pin;
   logic [7:0]            rdata_ff;
   logic [7:0]            nxt_rdata;
   logic                  rvalid_ff;
   logic                  nxt_rvalid;

   // Builds one status byte with reserved bits forced to zero
   // Reserved bits are tied here so no register can leak stray state
   function automatic logic [7:0] pad_byte(input logic [NC-1:0] bits);
      pad_byte = {{(8 - cta_pkg::CH_FIELD_W){1'b0}}, bits};
   endfunction : pad_byte

   // Read decoding shared by all registers; unmapped codes read zero
   // Mask codes read back too, so software can confirm what it wrote
   function automatic logic [7:0] read_mux(
      input logic [7:0]            addr,
      input logic [NL-1:0][NC-1:0] stat,
      input logic [NL-1:0][NC-1:0] mask
   );
      logic [NL-1:0] flags;
      for (int l = 0; l < NL; l++) begin
         flags[l] = |stat[l];
      end
      case (addr)
         cta_pkg::ADDR_SUMMARY: begin
            read_mux = 8'h00;
            read_mux[cta_pkg::SUM_FLAG_LSB +: NL] = flags;
         end
         cta_pkg::ADDR_LVL1:  read_mux = pad_byte(stat[0]);
         cta_pkg::ADDR_LVL2:  read_mux = pad_byte(stat[1]);
         cta_pkg::ADDR_LVL3:  read_mux = pad_byte(stat[2]);
         cta_pkg::ADDR_MASK1: read_mux = pad_byte(mask[0]);
         cta_pkg::ADDR_MASK2: read_mux = pad_byte(mask[1]);
         cta_pkg::ADDR_MASK3: read_mux = pad_byte(mask[2]);
         default:             read_mux = 8'h00;
      endcase
   endfunction : read_mux

   // One comparator per level and channel; on-chip shares a single limit
   // Far limits are indexed from zero for far diode 1, hence c-1
   // All comparators run every cycle; only the done strobe commits a result
   for (genvar l = 0; l < NL; l++) begin : g_lvl
      for (genvar c = 0; c < NC; c++) begin : g_ch
         logic [cta_pkg::TEMP_W-1:0] lim;
         if (c == cta_pkg::CH_ONCHIP) begin : g_onchip
            assign lim = lim_i.onchip_lim;
         end else begin : g_far
            assign lim = lim_i.far_lim[l][c-1];
         end
         cta_hyst_cmp u_cmp (
            .reading_i (meas_i.val[c]),
            .limit_i   (lim),
            .hyst_i    (lim_i.hyst),
            .cur_i     (stat_ff[l][c]),
            .nxt_o     (eval[l][c])
         );
      end
   end

   // Status bits move only on a finished conversion of an enabled channel
   // A held done level re-evaluates every cycle; a pulse gives one update
   // Disabled channels keep their bits, so a stale alarm stays visible
   always_comb begin
      nxt_stat = stat_ff;
      for (int l = 0; l < NL; l++) begin
         for (int c = 0; c < NC; c++) begin
            if (meas_i.done[c] && chan_en_i[c]) begin
               nxt_stat[l][c] = eval[l][c];
            end
         end
      end
   end

   // No bus path reaches the status bits, so writes there do nothing
   // Reset clears every level; a conversion must pass before an alarm returns
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int l = 0; l < NL; l++) begin
            stat_ff[l] <= cta_pkg::STATUS_RST;
         end
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // Mask registers; only the channel field is stored
   // Status and summary codes fall to the default, which keeps the masks
   always_comb begin
      nxt_mask = mask_ff;
      if (reg_wr_i) begin
         case (reg_addr_i)
            cta_pkg::ADDR_MASK1: nxt_mask[0] = reg_wdata_i[NC-1:0];
            cta_pkg::ADDR_MASK2: nxt_mask[1] = reg_wdata_i[NC-1:0];
            cta_pkg::ADDR_MASK3: nxt_mask[2] = reg_wdata_i[NC-1:0];
            default:             nxt_mask    = mask_ff;
         endcase
      end
   end

   // Reset hides the first level's on-chip bit and every bit of level three
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_ff[0] <= cta_pkg::MASK1_RST;
         mask_ff[1] <= cta_pkg::MASK2_RST;
         mask_ff[2] <= cta_pkg::MASK3_RST;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // Alarm level per pin; a mask of one hides the channel
   // Pin value has its own flop so enable and value change on one edge
   always_comb begin
      for (int l = 0; l < NL; l++) begin
         nxt_alarm[l] = |(stat_ff[l] & ~mask_ff[l]);
         nxt_pin[l]   = ~nxt_alarm[l];
      end
   end

   // Enable and value flops reset to a released pin
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alarm_ff <= '0;
         pin_ff   <= '1;
      end else begin
         alarm_ff <= nxt_alarm;
         pin_ff   <= nxt_pin;
      end
   end

   // Read data is captured on the strobe so it stays stable afterwards
   // Data keeps its value between reads, so a slow host still sees it
   always_comb begin
      nxt_rdata  = rdata_ff;
      nxt_rvalid = reg_rd_i;
      if (reg_rd_i) begin
         nxt_rdata = read_mux(reg_addr_i, stat_ff, mask_ff);
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff  <= cta_pkg::RDATA_RST;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Register port outputs straight from their flops
   always_comb begin
      reg_rdata_o  = rdata_ff;
      reg_rvalid_o = rvalid_ff;
   end

   // Pins pull low only while active; the level value is high when released
   always_comb begin
      alarm_out_first_oe_o  = alarm_ff[0];
      alarm_out_first_o     = pin_ff[0];
      alarm_out_second_oe_o = alarm_ff[1];
      alarm_out_second_o    = pin_ff[1];
      alarm_out_third_oe_o  = alarm_ff[2];
      alarm_out_third_o     = pin_ff[2];
   end

endmodule : cta_alarm_status

// ### shared/cta_pkg.sv
// Purpose: Shared constants and carriers of the critical alarm status block
// Assumes: Temperatures are two's complement codes, TEMP_W bits wide
// Notes:   Channel index 0 is on-chip, 1 is far diode 1, 2 is far diode 2
package cta_pkg;

   // Sizes
   localparam int TEMP_W  = 11;
   localparam int NUM_LVL = 3;
   localparam int NUM_CH  = 3;

   // Channel bit positions inside each level status register
   localparam int CH_ONCHIP = 0;
   localparam int CH_FAR1   = 1;
   localparam int CH_FAR2   = 2;

   // Command codes
   localparam logic [7:0] ADDR_SUMMARY = 8'h02;
   localparam logic [7:0] ADDR_LVL1    = 8'h08;
   localparam logic [7:0] ADDR_LVL2    = 8'h09;
   localparam logic [7:0] ADDR_LVL3    = 8'h0a;
   localparam logic [7:0] ADDR_MASK1   = 8'h0c;
   localparam logic [7:0] ADDR_MASK2   = 8'h0d;
   localparam logic [7:0] ADDR_MASK3   = 8'h0e;

   // Field positions
   localparam int SUM_FLAG_LSB = 1;    // Level 1 flag, levels 2 and 3 follow
   localparam int CH_FIELD_W   = 3;    // Bits 2..0 hold channels, 7..3 reserved

   // Reset values
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [2:0] MASK1_RST  = 3'h1;
   localparam logic [2:0] MASK2_RST  = 3'h0;
   localparam logic [2:0] MASK3_RST  = 3'h7;
   localparam logic [7:0] RDATA_RST  = 8'h00;

   // Conversion results, one reading and one done pulse per channel
   typedef struct packed {
      logic [NUM_CH-1:0][TEMP_W-1:0] val;
      logic [NUM_CH-1:0]             done;
   } cta_meas_t;

   // Thresholds: far limits per level and far channel, one on-chip limit
   typedef struct packed {
      logic [NUM_LVL-1:0][1:0][TEMP_W-1:0] far_lim;
      logic [TEMP_W-1:0]                   onchip_lim;
      logic [TEMP_W-1:0]                   hyst;
   } cta_limits_t;

endpackage : cta_pkg

// ### hw/cta_hyst_cmp.sv
// Purpose: Next value of one channel status bit with hysteresis
// Assumes: Reading and limit are signed codes; hysteresis is unsigned
// Notes:   Purely combinational; the caller decides when to take the result
`timescale 1ns/10ps
module cta_hyst_cmp (
   // Operands
   input  wire logic [cta_pkg::TEMP_W-1:0] reading_i,
   input  wire logic [cta_pkg::TEMP_W-1:0] limit_i,
   input  wire logic [cta_pkg::TEMP_W-1:0] hyst_i,
   input  wire logic                       cur_i,
   // Result
   output logic                            nxt_o
);

   logic signed [cta_pkg::TEMP_W+1:0] rd_ext;
   logic signed [cta_pkg::TEMP_W+1:0] lim_ext;
   logic signed [cta_pkg::TEMP_W+1:0] clr_thr;
   logic signed [cta_pkg::TEMP_W+1:0] hyst_ext;

   // Two extra bits: the lowest limit minus the largest hysteresis needs them
   always_comb begin
      rd_ext   = $signed({{2{reading_i[cta_pkg::TEMP_W-1]}}, reading_i});
      lim_ext  = $signed({{2{limit_i[cta_pkg::TEMP_W-1]}}, limit_i});
      hyst_ext = $signed({2'b00, hyst_i});
      clr_thr  = lim_ext - hyst_ext;
      if (rd_ext >= lim_ext) begin
         nxt_o = 1'b1;                         // At or over the limit
      end else if (rd_ext < clr_thr) begin
         nxt_o = 1'b0;                         // Below limit minus hysteresis
      end else begin
         nxt_o = cur_i;                        // Dead band keeps old state
      end
   end

endmodule : cta_hyst_cmp

// ### tb/cta_pin_host.sv
// Purpose: Host side of the three open-drain alarm pins
// Assumes: Each pin has a pull-up, so a released pin reads high
// Notes:   Passes on the driven value, so a wrong pin value shows up
`timescale 1ns/10ps
module cta_pin_host (
   // Driven side of the pins
   input  wire logic [2:0] pin_val_i,
   input  wire logic [2:0] pin_oe_i,
   // Wire levels seen by the host
   output logic      [2:0] line_o
);
   // Pull-up wins whenever nobody drives
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         line_o[k] = pin_oe_i[k] ? pin_val_i[k] : 1'b1;
      end
   end
endmodule : cta_pin_host

// ### tb/cta_alarm_monitor.sv
// Purpose: Port checks of the alarm status block
// Assumes: Read data answers one edge after the strobe
// Notes:   Pin release is tied to read-back status of the same cycle
`timescale 1ns/10ps
module cta_alarm_monitor (
   // Clock, reset and inputs
   input wire logic               sys_clk_i,
   input wire logic               reset_n_i,
   input wire cta_pkg::cta_meas_t meas_i,
   input wire logic [7:0]         reg_addr_i,
   input wire logic               reg_rd_i,
   input wire logic               reg_wr_i,
   // Watched outputs
   input wire logic [7:0]         reg_rdata_o,
   input wire logic               reg_rvalid_o,
   input wire logic               alarm_out_first_o,
   input wire logic               alarm_out_first_oe_o,
   input wire logic               alarm_out_third_o,
   input wire logic               alarm_out_third_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // A read strobe and its answer
   sequence s_read;
      reg_rd_i ##1 reg_rvalid_o;
   endsequence
   property p_answer; reg_rd_i |-> s_read; endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_cause; reg_rvalid_o |-> $past(reg_rd_i); endproperty
   a_cause: assert property (p_cause) else $error("answer without read");
   property p_resv;
      reg_rvalid_o && $past(reg_addr_i) inside {8'h08, 8'h09, 8'h0a} |-> reg_rdata_o[7:3] == 5'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved status bits set");
   property p_sum; reg_rvalid_o && $past(reg_addr_i) == 8'h02 |-> reg_rdata_o[0] == 1'b0; endproperty
   a_sum: assert property (p_sum) else $error("summary low bit set");
   property p_rel1; reg_rvalid_o && $past(reg_addr_i) == 8'h08 && reg_rdata_o == 8'h00
      |-> !alarm_out_first_oe_o; endproperty
   a_rel1: assert property (p_rel1) else $error("first pin held with clear status");
   property p_rel3; reg_rvalid_o && $past(reg_addr_i) == 8'h0a && reg_rdata_o == 8'h00
      |-> !alarm_out_third_oe_o; endproperty
   a_rel3: assert property (p_rel3) else $error("third pin held with clear status");
   property p_pin; alarm_out_first_o == !alarm_out_first_oe_o; endproperty
   a_pin: assert property (p_pin) else $error("first pin value disagrees with enable");
   // Pins move only after a conversion or a register write
   property p_hold; $past(meas_i.done, 2) == 3'h0 && !$past(reg_wr_i, 2)
      |-> $stable(alarm_out_first_oe_o) && $stable(alarm_out_third_oe_o); endproperty
   a_hold: assert property (p_hold) else $error("pin changed without cause");
endmodule : cta_alarm_monitor
bind cta_alarm_status cta_alarm_monitor u_mon (.sys_clk_i, .reset_n_i, .meas_i, .reg_addr_i,
   .reg_rd_i, .reg_wr_i, .reg_rdata_o, .reg_rvalid_o, .alarm_out_first_o, .alarm_out_first_oe_o,
   .alarm_out_third_o, .alarm_out_third_oe_o);

// ### tb/testbench.sv
// Purpose: Random conversions around the thresholds against a status model
// Assumes: Inputs change at the falling edge
// Notes:   Readings are picked at limit and limit minus hysteresis edges
`timescale 1ns/10ps
module testbench;
   logic                 sys_clk_i  = 1'b0;
   logic                 reset_n_i  = 1'b0;
   cta_pkg::cta_meas_t   meas       = '0;
   cta_pkg::cta_limits_t lim;
   logic [2:0]           en         = 3'h7;
   logic [7:0]           addr       = 8'h00;
   logic [7:0]           wdata      = 8'h00;
   logic                 rd         = 1'b0;
   logic                 wr         = 1'b0;
   logic [7:0]           rdata;
   logic                 rvalid;
   logic [2:0]           pv, oe, line;
   int                   num_errors = 0;
   int                   num_checks = 0;
   int                   cycles     = 0;
   int                   lt [3][3];
   logic [2:0]           st [3];
   logic [2:0]           mk [3];
   int                   offs [5]   = '{-7, -6, -1, 0, 3};
   cta_alarm_status DUT (.sys_clk_i, .reset_n_i, .meas_i(meas), .chan_en_i(en), .lim_i(lim),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .alarm_out_first_o(pv[0]), .alarm_out_first_oe_o(oe[0]),
      .alarm_out_second_o(pv[1]), .alarm_out_second_oe_o(oe[1]),
      .alarm_out_third_o(pv[2]), .alarm_out_third_oe_o(oe[2]));
   cta_pin_host u_host (.pin_val_i(pv), .pin_oe_i(oe), .line_o(line));
   // Clock and hang guard
   always #4 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   // Reads stay strobed back to back; the caller lowers the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk_i);
      check({7'h00, rvalid}, 8'h01);
      check(rdata, exp);
   endtask : rd_chk
   task automatic wr_op(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk_i);
      if (a >= 8'h0c && a <= 8'h0e)
         mk[a-8'h0c] = d[2:0];
   endtask : wr_op
   // One conversion; model sets at the limit, clears below limit minus hysteresis
   task automatic convert(input int ch, input int v, input logic e);
      meas.val[ch] = 11'(v);
      meas.done[ch] = 1'b1;
      en[ch] = e;
      @(negedge sys_clk_i);
      meas.done = 3'h0;
      for (int l = 0; l < 3; l++) begin
         if (e && v >= lt[l][ch])
            st[l][ch] = 1'b1;
         else if (e && v < lt[l][ch] - 6)
            st[l][ch] = 1'b0;
      end
   endtask : convert
   task automatic verify();
      wr = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      for (int l = 0; l < 3; l++) begin
         rd_chk(8'(8 + l), {5'h00, st[l]});
         rd_chk(8'(12 + l), {5'h00, mk[l]});
         check({7'h00, oe[l]}, {7'h00, |(st[l] & ~mk[l])});
         check({7'h00, line[l]}, {7'h00, ~|(st[l] & ~mk[l])});
      end
      rd_chk(8'h0b, 8'h00);
      rd_chk(8'h02, {4'h0, |st[2], |st[1], |st[0], 1'b0});
      rd = 1'b0;
   endtask : verify
   initial begin
      void'($urandom(55999));
      lim.hyst = 11'd6;
      lim.onchip_lim = 11'd100;
      for (int l = 0; l < 3; l++) begin
         lt[l][0] = 100;
         lt[l][1] = 80 + 10 * l;
         lt[l][2] = 85 + 10 * l;
         lim.far_lim[l][0] = 11'(lt[l][1]);
         lim.far_lim[l][1] = 11'(lt[l][2]);
         st[l] = 3'h0;
      end
      mk = '{3'h1, 3'h0, 3'h7};
      repeat (3) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      verify();
      // Random conversions with stray status writes and mask changes
      repeat (80) begin
         automatic int l = $urandom % 3;
         automatic int c = $urandom % 3;
         convert(c, lt[l][c] + offs[$urandom % 5], ($urandom % 4) != 0);
         if ($urandom % 3 == 0)
            wr_op(8'(8 + $urandom % 3), 8'($urandom));
         if ($urandom % 3 == 0)
            wr_op(8'(12 + $urandom % 3), 8'($urandom));
         verify();
      end
      // Reset in mid-run must bring status and masks back to reset values
      reset_n_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      for (int l = 0; l < 3; l++)
         st[l] = 3'h0;
      mk = '{3'h1, 3'h0, 3'h7};
      verify();
      convert(1, lt[0][1], 1'b1);
      verify();
      end_of_test();
   end
endmodule : testbench
